// ==== cfgrd_pkg.sv ====
// Constants, register map and state codes for the configuration space access block.
// Assumes a Wishbone classic slave with 32-bit data and one register per aligned word.
// What this block does
// - Config select steers access to config region.
// - Region is address half with bit 15 set.
// - User IDs 8000h-8003h readable and writable.
// - 8006h-8008h readable, writes refused.
// - Read of unlisted address clears data pair.
// - Next instruction runs, following two ignored.
// - Low data register holds bits 7 to 0.
// - High data register holds bits 13 to 8.
// - High data bits 7 and 6 read zero.
// - Low address register gives address bits 7:0.
// - High address register gives bits 14:8.
package cfgrd_pkg;

	// Register byte addresses on the bus.
	localparam logic [7:0] CFGRD_OFF_DATA_LOW  = 8'h00;
	localparam logic [7:0] CFGRD_OFF_DATA_HIGH = 8'h04;
	localparam logic [7:0] CFGRD_OFF_ADDR_LOW  = 8'h08;
	localparam logic [7:0] CFGRD_OFF_ADDR_HIGH = 8'h0C;
	localparam logic [7:0] CFGRD_OFF_CONTROL   = 8'h10;
	localparam logic [7:0] CFGRD_OFF_STATUS    = 8'h14;

	// Control register field positions.
	localparam int CFGRD_BIT_READ   = 0;
	localparam int CFGRD_BIT_WRITE  = 1;
	localparam int CFGRD_BIT_ENABLE = 2;
	localparam int CFGRD_BIT_CFGSEL = 6;

	// Reset values.
	localparam logic [7:0] CFGRD_RST_ADDR = 8'h00;
	localparam logic [7:0] CFGRD_RST_CTRL = 8'h00;
	localparam logic [7:0] CFGRD_RST_DATA = 8'h00;

	// Configuration region map.
	localparam logic [15:0] CFGRD_UID_FIRST = 16'h8000;
	localparam logic [15:0] CFGRD_UID_LAST  = 16'h8003;
	localparam logic [15:0] CFGRD_DEVID     = 16'h8006;
	localparam logic [15:0] CFGRD_CFGW_LAST = 16'h8008;
	localparam int          CFGRD_REGION_BIT = 15;

	// Cycles the core stays stalled after the one instruction that still runs.
	localparam int CFGRD_STALL_CYCLES = 2;

	// Access sequencer states, one-hot.
	typedef enum logic [2:0] {
		CFGRD_IDLE  = 3'b001,
		CFGRD_SLOT  = 3'b010,
		CFGRD_STALL = 3'b100
	} cfgrd_state_t;

endpackage

// ==== cfgrd_space.sv ====
// Configuration region storage: user IDs, device ID and two configuration words.
// Assumes the caller gives a 16-bit word address with bit 15 marking the region.
`timescale 1ns/1ns
module cfgrd_space
	import cfgrd_pkg::*;
#(
	parameter logic [13:0] DEVICE_ID = 14'h1234, // Arbitrary neutral identity value.
	parameter logic [13:0] CFG_WORD1 = 14'h3FFF,
	parameter logic [13:0] CFG_WORD2 = 14'h3FFF
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] addr_i,
	input  wire logic        wr_i,
	input  wire logic [13:0] wdata_i,
	output logic      [13:0] rdata_o,
	output logic             hit_o
);
	logic [13:0] uid_mem [0:3];
	logic        is_uid;

	assign is_uid = addr_i >= CFGRD_UID_FIRST && addr_i <= CFGRD_UID_LAST;

	// Lookup is combinational; unlisted addresses report a miss so the caller clears.
	always_comb begin
		rdata_o = 14'h0000;
		hit_o   = 1'b1;
		if (is_uid) begin
			rdata_o = uid_mem[addr_i[1:0]];
		end else if (addr_i == CFGRD_DEVID) begin
			rdata_o = DEVICE_ID;
		end else if (addr_i == CFGRD_CFGW_LAST - 16'h0001) begin
			rdata_o = CFG_WORD1;
		end else if (addr_i == CFGRD_CFGW_LAST) begin
			rdata_o = CFG_WORD2;
		end else begin
			hit_o = 1'b0;
		end
	end

	// Only user ID words take writes; all other addresses keep their content.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++) begin
				uid_mem[i] <= 14'h0000;
			end
		end else if (wr_i && is_uid) begin
			uid_mem[addr_i[1:0]] <= wdata_i;
		end
	end
endmodule // cfgrd_space

// ==== cfgrd_top.sv ====
// Self-programming register block reaching the configuration region over Wishbone.
// Assumes a classic Wishbone master; normal program memory and data EEPROM lie outside.
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/1ns
module cfgrd_top
	import cfgrd_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	output logic             err_o,
	output logic             cpu_stall_o,
	output logic             cfg_access_o
);
	logic        [7:0]  data_low_q;
	logic        [5:0]  data_high_q;
	logic        [7:0]  addr_low_q;
	logic        [6:0]  addr_high_q;
	logic        [7:0]  ctrl_q;
	logic               refused_q;
	cfgrd_state_t       state_q;
	logic        [1:0]  stall_cnt_q;
	logic        [15:0] target;
	logic        [13:0] space_rdata;
	logic               space_hit;
	logic               space_wr;
	logic               req;
	logic               bus_wr;
	logic               mapped;
	logic        [31:0] rd_mux;
	logic        [13:0] data_word;

	// Range test for the writable user ID words, shared by the flag logic and the checks.
	// The storage block keeps its own decode, so both must move together if the map changes.
	function automatic logic user_id_hit(input logic [15:0] a);
		return a >= CFGRD_UID_FIRST && a <= CFGRD_UID_LAST;
	endfunction

	// The region sits in the upper half; bit 15 is forced by the select bit.
	// Software cannot reach the region by address alone, which keeps stray pointers out.
	assign target = {ctrl_q[CFGRD_BIT_CFGSEL], addr_high_q, addr_low_q};
	assign req    = cyc_i && stb_i && !ack_o && !err_o;
	assign bus_wr = req && we_i && sel_i[0];
	assign mapped = adr_i == CFGRD_OFF_DATA_LOW || adr_i == CFGRD_OFF_DATA_HIGH
		|| adr_i == CFGRD_OFF_ADDR_LOW || adr_i == CFGRD_OFF_ADDR_HIGH
		|| adr_i == CFGRD_OFF_CONTROL || adr_i == CFGRD_OFF_STATUS;

	// The data pair as one word, in the order that the storage and the checks expect.
	assign data_word = {data_high_q, data_low_q};

	// Write pulse to storage when the write trigger fires with the enable and select bits set.
	assign space_wr = state_q == CFGRD_SLOT && ctrl_q[CFGRD_BIT_WRITE]
		&& ctrl_q[CFGRD_BIT_ENABLE] && ctrl_q[CFGRD_BIT_CFGSEL];

	// Storage for the region; it decodes the word address and refuses writes itself.
	cfgrd_space cfgrd_space_inst (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.addr_i  (target),
		.wr_i    (space_wr),
		.wdata_i (data_word),
		.rdata_o (space_rdata),
		.hit_o   (space_hit)
	);

	// Readback mux; unused upper bits read zero.
	// Bit 7 of the high address reads as one, since the unimplemented bit there is tied high.
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (adr_i)
			CFGRD_OFF_DATA_LOW:  rd_mux[7:0] = data_low_q;
			CFGRD_OFF_DATA_HIGH: rd_mux[7:0] = {2'b00, data_high_q};
			CFGRD_OFF_ADDR_LOW:  rd_mux[7:0] = addr_low_q;
			CFGRD_OFF_ADDR_HIGH: rd_mux[7:0] = {1'b1, addr_high_q};
			CFGRD_OFF_CONTROL:   rd_mux[7:0] = ctrl_q;
			CFGRD_OFF_STATUS:    rd_mux[7:0] = {6'h00, refused_q, cpu_stall_o};
			default:             rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus answer: ack one cycle after the request, err for unmapped offsets.
	// Registering the answer costs one wait state but keeps every output straight from a flop.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= req && mapped;
			err_o <= req && !mapped;
			dat_o <= rd_mux;
		end
	end

	// Address registers are plain software-owned storage.
	// They are not locked during a stall; the fetch has already used them by then.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_low_q  <= CFGRD_RST_ADDR;
			addr_high_q <= CFGRD_RST_ADDR[6:0];
		end else if (bus_wr && adr_i == CFGRD_OFF_ADDR_LOW) begin
			addr_low_q <= dat_i[7:0];
		end else if (bus_wr && adr_i == CFGRD_OFF_ADDR_HIGH) begin
			addr_high_q <= dat_i[6:0];
		end
	end

	// Data pair: a finished read loads it, else software writes it.
	// The fetch wins over a bus write in the same cycle, since the core stalls right after.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_low_q  <= CFGRD_RST_DATA;
			data_high_q <= CFGRD_RST_DATA[5:0];
		end else if (state_q == CFGRD_SLOT && ctrl_q[CFGRD_BIT_READ] && ctrl_q[CFGRD_BIT_CFGSEL]) begin
			// A miss returns zero from storage, which clears both halves.
			data_low_q  <= space_hit ? space_rdata[7:0] : 8'h00;
			data_high_q <= space_hit ? space_rdata[13:8] : 6'h00;
		end else if (bus_wr && adr_i == CFGRD_OFF_DATA_LOW) begin
			data_low_q <= dat_i[7:0];
		end else if (bus_wr && adr_i == CFGRD_OFF_DATA_HIGH) begin
			data_high_q <= dat_i[5:0];
		end
	end

	// Control: triggers can only be set by software and are cleared by hardware.
	// A set landing in the very cycle of the hardware clear is lost, so software must
	// not rearm a trigger until it has read it back clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= CFGRD_RST_CTRL;
		end else begin
			if (bus_wr && adr_i == CFGRD_OFF_CONTROL) begin
				ctrl_q <= dat_i[7:0] | (ctrl_q & 8'h03);
			end
			if (state_q == CFGRD_STALL && stall_cnt_q == 2'd1) begin
				ctrl_q[CFGRD_BIT_READ]  <= 1'b0;
				ctrl_q[CFGRD_BIT_WRITE] <= 1'b0;
			end
		end
	end

	// Refused-write flag, set when a write hits a read-only or unlisted address.
	// The hardware set comes first, so it wins over a clear arriving in the same cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			refused_q <= 1'b0;
		end else if (state_q == CFGRD_SLOT && ctrl_q[CFGRD_BIT_WRITE] && ctrl_q[CFGRD_BIT_CFGSEL]) begin
			refused_q <= !user_id_hit(target);
		end else if (bus_wr && adr_i == CFGRD_OFF_STATUS && dat_i[1]) begin
			refused_q <= 1'b0;
		end
	end

	// Sequencer: one slot for the next instruction, then the core stalls.
	// The counter is two bits wide, so the stall length constant must stay below four.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q     <= CFGRD_IDLE;
			stall_cnt_q <= 2'd0;
			cpu_stall_o <= 1'b0;
		end else begin
			unique case (state_q)
				CFGRD_IDLE: begin
					if (ctrl_q[CFGRD_BIT_READ] || ctrl_q[CFGRD_BIT_WRITE]) begin
						state_q <= CFGRD_SLOT;
					end
				end
				CFGRD_SLOT: begin
					state_q     <= CFGRD_STALL;
					stall_cnt_q <= 2'(CFGRD_STALL_CYCLES);
					cpu_stall_o <= 1'b1;
				end
				CFGRD_STALL: begin
					stall_cnt_q <= stall_cnt_q - 2'd1;
					if (stall_cnt_q == 2'd1) begin
						state_q     <= CFGRD_IDLE;
						cpu_stall_o <= 1'b0;
					end
				end
			endcase
		end
	end

	// Marks that the target is the configuration region.
	// It lags the select bit by one cycle; it is a status hint, not part of the decode.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_access_o <= 1'b0;
		end else begin
			cfg_access_o <= ctrl_q[CFGRD_BIT_CFGSEL];
		end
	end

	a_read_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == CFGRD_SLOT && ctrl_q[CFGRD_BIT_READ] && ctrl_q[CFGRD_BIT_CFGSEL] && !space_hit
		|=> data_low_q == 8'h00 && data_high_q == 6'h00)
		else $error("Read of unlisted address did not clear data.");

	a_high_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && $past(adr_i) == CFGRD_OFF_DATA_HIGH && !$past(we_i) |-> dat_o[7:6] == 2'b00)
		else $error("High data top bits not zero.");

	a_slot_then_stall: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == CFGRD_IDLE && ctrl_q[CFGRD_BIT_READ] |=> !cpu_stall_o ##1 cpu_stall_o[*2] ##1 !cpu_stall_o)
		else $error("Stall timing after trigger is wrong.");

	a_trig_clears: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(cpu_stall_o) |-> !ctrl_q[CFGRD_BIT_READ])
		else $error("Read trigger still set when execution resumes.");

	a_ro_kept: assert property (@(posedge clk_i) disable iff (rst_i)
		space_wr && target >= CFGRD_DEVID |=> refused_q)
		else $error("Write to read-only word not refused.");

	a_uid_write: assert property (@(posedge clk_i) disable iff (rst_i)
		space_wr && target == CFGRD_UID_FIRST |=> !refused_q)
		else $error("User ID write refused.");

	a_region_bit: assert property (@(posedge clk_i) disable iff (rst_i)
		space_hit |-> target[CFGRD_REGION_BIT])
		else $error("Region hit without bit 15.");

	a_low_write: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_wr && adr_i == CFGRD_OFF_DATA_LOW && state_q != CFGRD_SLOT |=> data_low_q == $past(dat_i[7:0]))
		else $error("Low data write lost.");

	// The checks below watch the register file, the region map and the stall timing.
	// Each one is tied to the logic that it guards, so a broken path trips its own label.

	// Register readback and storage: the bus must see the stored bits.
	// Unimplemented high data bits 7 and 6 are covered by the zero check above.
	a_low_byte_read: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && $past(adr_i) == CFGRD_OFF_DATA_LOW && !$past(we_i)
		|-> dat_o[7:0] == $past(data_low_q))
		else $error("Low data readback differs from the stored byte.");

	a_high_read: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && $past(adr_i) == CFGRD_OFF_DATA_HIGH && !$past(we_i)
		|-> dat_o[5:0] == $past(data_high_q))
		else $error("High data readback differs from the stored bits.");

	a_high_store: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_wr && adr_i == CFGRD_OFF_DATA_HIGH && state_q != CFGRD_SLOT
		|=> data_high_q == $past(dat_i[5:0]))
		else $error("High data write lost.");

	a_addr_low_store: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_wr && adr_i == CFGRD_OFF_ADDR_LOW
		|=> target[7:0] == $past(dat_i[7:0]))
		else $error("Low address write did not reach the target address.");

	a_addr_high_store: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_wr && adr_i == CFGRD_OFF_ADDR_HIGH
		|=> target[14:8] == $past(dat_i[6:0]))
		else $error("High address write did not reach the target address.");

	a_status_refused: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o && $past(adr_i) == CFGRD_OFF_STATUS && !$past(we_i)
		|-> dat_o[1] == $past(refused_q))
		else $error("Status readback does not show the refused flag.");

	// Region map: every listed word answers; the low half and the gap after the user IDs miss.
	// These hold on the target alone, whether or not a fetch is running.
	a_low_half_miss: assert property (@(posedge clk_i) disable iff (rst_i)
		!target[CFGRD_REGION_BIT]
		|-> !space_hit)
		else $error("Region answered outside its address half.");

	a_uid_hit: assert property (@(posedge clk_i) disable iff (rst_i)
		user_id_hit(target)
		|-> space_hit)
		else $error("User ID word not readable.");

	a_id_words_hit: assert property (@(posedge clk_i) disable iff (rst_i)
		target == CFGRD_DEVID || target == CFGRD_CFGW_LAST - 16'h0001 || target == CFGRD_CFGW_LAST
		|-> space_hit)
		else $error("Identity or configuration word not readable.");

	a_gap_miss: assert property (@(posedge clk_i) disable iff (rst_i)
		target > CFGRD_UID_LAST && target < CFGRD_DEVID
		|-> !space_hit)
		else $error("Unlisted address inside the region answered.");

	// Transfers between the data pair and the storage.
	// Bus writes in the fetch cycle are left out of the select-off and storage checks, as they move the target or the data.
	a_sel_off_keep: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == CFGRD_SLOT && ctrl_q[CFGRD_BIT_READ] && !ctrl_q[CFGRD_BIT_CFGSEL] && !bus_wr
		|=> $stable(data_word))
		else $error("Read with the select bit clear changed the data pair.");

	a_read_loads: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == CFGRD_SLOT && ctrl_q[CFGRD_BIT_READ] && ctrl_q[CFGRD_BIT_CFGSEL] && space_hit
		|=> data_word == $past(space_rdata))
		else $error("Fetched word not loaded into the data pair.");

	a_uid_stored: assert property (@(posedge clk_i) disable iff (rst_i)
		space_wr && user_id_hit(target) && !bus_wr
		|=> space_rdata == $past(data_word))
		else $error("User ID write did not store the data pair.");

	a_ro_unchanged: assert property (@(posedge clk_i) disable iff (rst_i)
		space_wr && !user_id_hit(target) && !bus_wr
		|=> $stable(space_rdata))
		else $error("Refused write changed the stored word.");

	a_refused_flag: assert property (@(posedge clk_i) disable iff (rst_i)
		state_q == CFGRD_SLOT && ctrl_q[CFGRD_BIT_WRITE] && ctrl_q[CFGRD_BIT_CFGSEL] && !user_id_hit(target)
		|=> refused_q)
		else $error("Refused write not flagged.");

	// Stall timing and the self-clearing trigger.
	// The core runs one slot, stalls for the set length and resumes with the trigger clear.
	a_stall_two: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(cpu_stall_o)
		|=> cpu_stall_o ##1 !cpu_stall_o)
		else $error("Stall did not last two cycles.");

	a_stall_after_slot: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(cpu_stall_o)
		|-> $past(state_q) == CFGRD_SLOT)
		else $error("Stall began without the executed slot.");

	a_trig_held: assert property (@(posedge clk_i) disable iff (rst_i)
		cpu_stall_o
		|-> ctrl_q[CFGRD_BIT_READ] || ctrl_q[CFGRD_BIT_WRITE])
		else $error("Trigger cleared before the stall ended.");

	a_resume_idle: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(cpu_stall_o)
		|-> state_q == CFGRD_IDLE)
		else $error("Execution resumed while the sequencer was busy.");

	a_select_copy: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1
		|-> cfg_access_o == $past(ctrl_q[CFGRD_BIT_CFGSEL]))
		else $error("Region marker does not follow the select bit.");

endmodule // cfgrd_top

// ==== cfgrd_top_bench.sv ====
// Self-checking bench for the configuration space access block.
// Assumes the block answers each Wishbone request within a few cycles.
`timescale 1ns/1ns
module cfgrd_top_bench
	import cfgrd_pkg::*;
;
	localparam logic [13:0] DEV_ID = 14'h1234; // Arbitrary value, matches the storage default.
	localparam logic [13:0] CFG_W  = 14'h3FFF;

	logic        clk_i;
	logic        rst_i;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        err_o;
	logic        cpu_stall_o;
	logic        cfg_access_o;
	logic [31:0] rv;
	logic        last_err;
	logic [13:0] w;
	logic [13:0] xp;
	int          mismatches = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          stall_len = 0;
	int          stall_last = 0;
	int          stall_runs = 0;

	cfgrd_top cfgrd_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .err_o(err_o), .cpu_stall_o(cpu_stall_o), .cfg_access_o(cfg_access_o));

	// Free-running core clock.
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Measures each stall run and cuts a hang short.
	always @(posedge clk_i) begin
		cycles++;
		if (cpu_stall_o === 1'b1) begin
			stall_len++;
		end else if (stall_len != 0) begin
			stall_last = stall_len;
			stall_runs++;
			stall_len = 0;
		end
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
		check_count++;
		if (seen !== expv) begin
			mismatches++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// One classic cycle; the request holds until ack or err is sampled high.
	task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= wr;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		do begin
			@(posedge clk_i);
		end while (!(ack_o === 1'b1 || err_o === 1'b1));
		rv = dat_o;
		last_err = err_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// Loads address and data, fires the control value, waits for the trigger to self-clear.
	task automatic cfg_op(input logic [7:0] a, input logic [13:0] d, input logic [7:0] ctl);
		int r0;
		int n;
		wb(1'b1, CFGRD_OFF_ADDR_LOW, {24'h0, a});
		wb(1'b1, CFGRD_OFF_ADDR_HIGH, 32'h0);
		wb(1'b1, CFGRD_OFF_DATA_LOW, {24'h0, d[7:0]});
		wb(1'b1, CFGRD_OFF_DATA_HIGH, {26'h0, d[13:8]});
		r0 = stall_runs;
		wb(1'b1, CFGRD_OFF_CONTROL, {24'h0, ctl});
		n = 0;
		do begin
			wb(1'b0, CFGRD_OFF_CONTROL, 32'h0);
			n++;
		end while (rv[1:0] !== 2'b00 && n < 20);
		chk({30'h0, rv[1:0]}, 32'h0);
		if (ctl[0]) begin
			chk(stall_runs - r0, 32'h1);
			chk(stall_last, CFGRD_STALL_CYCLES);
		end
		chk({31'h0, cfg_access_o}, {31'h0, ctl[CFGRD_BIT_CFGSEL]});
		wb(1'b0, CFGRD_OFF_DATA_LOW, 32'h0);
		w[7:0] = rv[7:0];
		wb(1'b0, CFGRD_OFF_DATA_HIGH, 32'h0);
		chk({30'h0, rv[7:6]}, 32'h0);
		w[13:8] = rv[5:0];
	endtask

	// Main sequence: register fields, the whole region map, then writes.
	initial begin
		rst_i = 1'b1;
		cyc_i = 1'b0;
		stb_i = 1'b0;
		we_i = 1'b0;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, CFGRD_OFF_ADDR_LOW, 32'h0);
		chk(rv, 32'h0);
		wb(1'b0, CFGRD_OFF_ADDR_HIGH, 32'h0);
		chk(rv, 32'h80);
		wb(1'b1, CFGRD_OFF_ADDR_LOW, 32'hA5);
		wb(1'b0, CFGRD_OFF_ADDR_LOW, 32'h0);
		chk(rv, 32'hA5);
		wb(1'b1, CFGRD_OFF_ADDR_HIGH, 32'h2A);
		wb(1'b0, CFGRD_OFF_ADDR_HIGH, 32'h0);
		chk(rv, 32'hAA);
		wb(1'b1, CFGRD_OFF_DATA_LOW, 32'hC3);
		wb(1'b0, CFGRD_OFF_DATA_LOW, 32'h0);
		chk(rv, 32'hC3);
		wb(1'b1, CFGRD_OFF_DATA_HIGH, 32'hFF);
		wb(1'b0, CFGRD_OFF_DATA_HIGH, 32'h0);
		chk(rv, 32'h3F);
		wb(1'b0, 8'h18, 32'h0);
		chk({31'h0, last_err}, 32'h1); // Unmapped offset must be refused.
		$display("test register fields done");
		// Data pair is preset nonzero so that clearing on unlisted reads shows.
		for (int a = 0; a < 9; a++) begin
			cfg_op(8'(a), 14'h3FFF, 8'h41);
			xp = (a == 6) ? DEV_ID : (a > 6) ? CFG_W : 14'h0000;
			chk({18'h0, w}, {18'h0, xp});
		end
		$display("test region reads done");
		cfg_op(8'h02, 14'h2D5A, 8'h46);
		wb(1'b0, CFGRD_OFF_STATUS, 32'h0);
		chk({31'h0, rv[1]}, 32'h0);
		cfg_op(8'h02, 14'h3FFF, 8'h41);
		chk({18'h0, w}, 32'h2D5A);
		cfg_op(8'h06, 14'h0000, 8'h46);
		wb(1'b0, CFGRD_OFF_STATUS, 32'h0);
		chk({31'h0, rv[1]}, 32'h1);
		wb(1'b1, CFGRD_OFF_STATUS, 32'h2);
		wb(1'b0, CFGRD_OFF_STATUS, 32'h0);
		chk({31'h0, rv[1]}, 32'h0);
		cfg_op(8'h06, 14'h3FFF, 8'h41);
		chk({18'h0, w}, {18'h0, DEV_ID});
		cfg_op(8'h04, 14'h1111, 8'h46);
		cfg_op(8'h04, 14'h3FFF, 8'h41);
		chk({18'h0, w}, 32'h0);
		$display("test region writes done");
		// Reads with the select bit clear must leave the data pair alone.
		cfg_op(8'h00, 14'h1357, 8'h01);
		chk({18'h0, w}, 32'h1357);
		$display("test select off done");
		// A reset in mid-run restores the registers and the user ID words.
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, CFGRD_OFF_ADDR_HIGH, 32'h0);
		chk(rv, 32'h80);
		cfg_op(8'h02, 14'h3FFF, 8'h41);
		chk({18'h0, w}, 32'h0);
		$display("test mid-run reset done");
		conclude();
	end
endmodule // cfgrd_top_bench
